//--- core/tbi_tlb_tags.sv
// Function
// - every entry tagged with its stream world
// - asid stored only for non-global asid-world va
// - vm tag for kernel and secure with stage 2
// - sharing flag recorded for asid-world va entries
// - hypervisor and monitor may skip sharing flag
// - hit needs world, asid and vm tags agreeing
// - asid tag width follows wide asid capability
// - vm tag width follows wide vm capability
// - kernel entries take stream stage-2 vm tag
// - no stage 2 means no vm tag
// - broadcast support optional, shown in capability bit
// - act only on broadcasts covering our domain
// - private maintenance bit drops that security state
// - drop unimplemented stage or state, keep rest
// - without stage 2 broadcasts match vm 0
// - sender lacking hypervisor implies vm 0
// - non-shared entries may skip asid-matching broadcasts
// - shared entries always hit; stage 2 unaffected
// - queued commands and non-global lookup ignore flag
// - asid-less worlds ignore asid; invalidate-all removes
// - configuration caches need no tags
// - global entry hits same world and flag only
//
// Added by the designer: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "tbi_defs.svh"

module tbi_tlb_tags
    import tbi_pkg::*;
(
    // clock and reset
    input  wire logic                      clock,
    input  wire logic                      rst_n,
    // register port
    input  wire logic [`TBI_ADDR_W-1:0]    regAddr,
    input  wire logic [31:0]               regWrData,
    input  wire logic                      regWr,
    input  wire logic                      regRd,
    output logic [31:0]                    regRdData,
    // translation fill from the walker
    input  wire logic                      insValid,
    input  wire tbi_pkg::tbi_world_t       insWorld,
    input  wire logic                      insIpa,
    input  wire logic                      insNotGlobal,
    input  wire logic                      insAset,
    input  wire logic [15:0]               insAsid,
    input  wire logic [15:0]               insVmid,
    input  wire logic [`TBI_PAGE_W-1:0]    insPage,
    input  wire logic [`TBI_PAGE_W-1:0]    insOutPage,
    // lookup
    input  wire logic                      lkValid,
    input  wire tbi_pkg::tbi_world_t       lkWorld,
    input  wire logic                      lkIpa,
    input  wire logic                      lkAset,
    input  wire logic [15:0]               lkAsid,
    input  wire logic [15:0]               lkVmid,
    input  wire logic [`TBI_PAGE_W-1:0]    lkPage,
    output logic                           lkDone,
    output logic                           lkHit,
    output logic [`TBI_PAGE_W-1:0]         lkOutPage,
    // queued invalidation command
    input  wire logic                      cmdValid,
    input  wire tbi_pkg::tbi_op_t          cmdOp,
    input  wire tbi_pkg::tbi_world_t       cmdWorld,
    input  wire logic                      cmdIpa,
    input  wire logic [15:0]               cmdAsid,
    input  wire logic [15:0]               cmdVmid,
    input  wire logic [`TBI_PAGE_W-1:0]    cmdPage,
    // broadcast invalidation from the interconnect
    input  wire logic                      bcValid,
    input  wire tbi_pkg::tbi_op_t          bcOp,
    input  wire tbi_pkg::tbi_world_t       bcWorld,
    input  wire tbi_pkg::tbi_stage_t       bcStage,
    input  wire logic                      bcOuter,
    input  wire logic                      bcNoEl2,
    input  wire logic [15:0]               bcAsid,
    input  wire logic [15:0]               bcVmid,
    input  wire logic [`TBI_PAGE_W-1:0]    bcPage,
    output logic                           bcAck
);
    import tbi_pkg::*;

    localparam int N = `TBI_ENTRIES;

    // entry storage; translation cache only, config caches live elsewhere
    logic                   entValid_r [N];
    tbi_world_t             entWorld_r [N];
    logic                   entIpa_r   [N];
    logic                   entAsidV_r [N];
    logic [15:0]            entAsid_r  [N];
    logic                   entVmidV_r [N];
    logic [15:0]            entVmid_r  [N];
    logic                   entAsetV_r [N];
    logic                   entAset_r  [N];
    logic [`TBI_PAGE_W-1:0] entPage_r  [N];
    logic [`TBI_PAGE_W-1:0] entOut_r   [N];

    // software state
    logic [`TBI_CTRL_W-1:0] ctrl_r;
    logic [`TBI_CNT_W-1:0]  bcAccCnt_r;
    logic [`TBI_CNT_W-1:0]  bcDropCnt_r;
    logic [`TBI_CNT_W-1:0]  lkHitCnt_r;
    logic [`TBI_CNT_W-1:0]  lkMissCnt_r;
    logic [`TBI_IDX_W-1:0]  victim_r;

    // fill tags
    logic        tagAsidV;
    logic [15:0] tagAsid;
    logic        tagVmidV;
    logic [15:0] tagVmid;
    logic        tagAsetV;
    logic        tagAset;

    // broadcast verdict
    logic        bcAccept;
    logic        s1Eff;
    logic        s2Eff;
    logic [15:0] bcEffVmid;
    logic [15:0] asidMask;
    logic [15:0] vmidMask;

    // per-entry results
    logic [N-1:0] hitVec;
    logic [N-1:0] cmdKill;
    logic [N-1:0] bcKill;
    logic [N-1:0] freeVec;

    // replacement and lookup selection
    logic                   anyFree;
    logic [`TBI_IDX_W-1:0]  freeIdx;
    logic [`TBI_IDX_W-1:0]  insIdx;
    logic                   anyHit;
    logic [`TBI_PAGE_W-1:0] hitOut;
    logic [`TBI_IDX_W:0]    occCount;

    assign asidMask = `TBI_CAP_WIDE_ASID_CAPABILITY ? `TBI_ID_WIDE_MASK
                                      : `TBI_ID_NARROW_MASK;
    assign vmidMask = `TBI_CAP_WIDE_VMID_CAPABILITY ? `TBI_ID_WIDE_MASK
                                      : `TBI_ID_NARROW_MASK;

    tbi_tag_build u_tag (
        .insWorld     (insWorld),
        .insIpa       (insIpa),
        .insNotGlobal (insNotGlobal),
        .insAset      (insAset),
        .insAsid      (insAsid),
        .insVmid      (insVmid),
        .tagAsidV     (tagAsidV),
        .tagAsid      (tagAsid),
        .tagVmidV     (tagVmidV),
        .tagVmid      (tagVmid),
        .tagAsetV     (tagAsetV),
        .tagAset      (tagAset)
    );

    tbi_bcast_filter u_filt (
        .bcValid   (bcValid),
        .bcWorld   (bcWorld),
        .bcStage   (bcStage),
        .bcOuter   (bcOuter),
        .bcNoEl2   (bcNoEl2),
        .bcVmid    (bcVmid),
        .ptmNonSec (ctrl_r[`TBI_CTRL_PTM_NS]),
        .ptmSec    (ctrl_r[`TBI_CTRL_PTM_S]),
        .devOuter  (ctrl_r[`TBI_CTRL_OUTER]),
        .accept    (bcAccept),
        .s1Eff     (s1Eff),
        .s2Eff     (s2Eff),
        .effVmid   (bcEffVmid)
    );

    // scope of an op against one entry; asid-less entries ignore the asid
    function automatic logic scopeHit(
        input tbi_op_t                op,
        input logic                   asidV,
        input logic                   asidEq,
        input logic                   pageEq,
        input logic                   asidWorldVa
    );
        logic r;
        r = 1'b0;
        case (op)
            TBI_OP_ALL:      r = 1'b1;
            TBI_OP_ASID:     r = asidV ? asidEq : !asidWorldVa;
            TBI_OP_ADDR:     r = pageEq && (!asidV || asidEq);
            TBI_OP_ADDR_ALL: r = pageEq;
            default:         r = 1'b0;
        endcase
        return r;
    endfunction

    // match logic, one copy per entry
    genvar g;
    generate
        for (g = 0; g < N; g++)
        begin : g_ent
            logic lkTagOk;
            logic lkVmOk;
            logic cmdVmOk;
            logic bcVmOk;
            logic bcStageOk;
            logic bcSkip;

            // global entries pair with the same sharing flag only
            assign lkTagOk = entAsidV_r[g]
                ? (entAsid_r[g] == (lkAsid & asidMask))
                : (!entAsetV_r[g] || entAset_r[g] == lkAset);
            assign lkVmOk = !entVmidV_r[g]
                         || entVmid_r[g] == (lkVmid & vmidMask);
            assign hitVec[g] = lkValid && entValid_r[g]
                            && entWorld_r[g] == lkWorld
                            && entIpa_r[g] == lkIpa
                            && entPage_r[g] == lkPage
                            && lkTagOk && lkVmOk;

            // queued commands: flag plays no part
            assign cmdVmOk = !entVmidV_r[g]
                          || entVmid_r[g] == (cmdVmid & vmidMask);
            assign cmdKill[g] = cmdValid && entValid_r[g]
                && entWorld_r[g] == cmdWorld
                && (cmdOp == TBI_OP_ALL || entIpa_r[g] == cmdIpa)
                && cmdVmOk
                && scopeHit(cmdOp, entAsidV_r[g],
                            entAsid_r[g] == (cmdAsid & asidMask),
                            entPage_r[g] == cmdPage,
                            entAsetV_r[g]);

            // broadcast: ipa entries are stage 2 information
            assign bcVmOk = !entVmidV_r[g] || entVmid_r[g] == bcEffVmid;
            assign bcStageOk = entIpa_r[g] ? s2Eff : s1Eff;
            // non-shared va may dodge asid-matching scopes only
            assign bcSkip = entAsetV_r[g] && entAset_r[g] && !entIpa_r[g]
                         && (bcOp == TBI_OP_ASID
                             || bcOp == TBI_OP_ADDR);
            assign bcKill[g] = bcAccept && entValid_r[g]
                && entWorld_r[g] == bcWorld && bcVmOk && bcStageOk
                && !bcSkip
                && scopeHit(bcOp, entAsidV_r[g],
                            entAsid_r[g] == (bcAsid & asidMask),
                            entPage_r[g] == bcPage,
                            entAsetV_r[g]);

            assign freeVec[g] = !entValid_r[g];
        end
    endgenerate

    // first free slot, hit selection and occupancy
    always_comb
    begin
        anyFree  = 1'b0;
        freeIdx  = '0;
        anyHit   = 1'b0;
        hitOut   = '0;
        occCount = '0;
        for (int i = N - 1; i >= 0; i--)
        begin
            if (freeVec[i])
            begin
                anyFree = 1'b1;
                freeIdx = i[`TBI_IDX_W-1:0];
            end
            if (hitVec[i])
            begin
                anyHit = 1'b1;
                hitOut = entOut_r[i];
            end
            occCount = occCount + {{`TBI_IDX_W{1'b0}}, entValid_r[i]};
        end
    end

    // free slot preferred, otherwise round robin victim
    assign insIdx = anyFree ? freeIdx : victim_r;

    // entry valid bits; a fill into a slot wins over its old contents
    always_ff @(posedge clock)
    begin
        for (int i = 0; i < N; i++)
        begin
            if (!rst_n)
                entValid_r[i] <= 1'b0;
            else if (insValid && insIdx == i[`TBI_IDX_W-1:0])
                entValid_r[i] <= 1'b1;
            else if (cmdKill[i] || bcKill[i])
                entValid_r[i] <= 1'b0;
        end
    end

    // entry tags and payload; no reset needed behind the valid bit
    always_ff @(posedge clock)
    begin
        for (int i = 0; i < N; i++)
        begin
            if (insValid && insIdx == i[`TBI_IDX_W-1:0])
            begin
                entWorld_r[i] <= insWorld;
                entIpa_r[i]   <= insIpa;
                entAsidV_r[i] <= tagAsidV;
                entAsid_r[i]  <= tagAsid;
                entVmidV_r[i] <= tagVmidV;
                entVmid_r[i]  <= tagVmid;
                entAsetV_r[i] <= tagAsetV;
                entAset_r[i]  <= tagAset;
                entPage_r[i]  <= insPage;
                entOut_r[i]   <= insOutPage;
            end
        end
    end

    // victim pointer steps on every fill into a full table
    always_ff @(posedge clock)
    begin
        if (!rst_n)
            victim_r <= '0;
        else if (insValid && !anyFree)
            victim_r <= victim_r + 1'b1;
    end

    // lookup answer one cycle after the request
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            lkDone    <= 1'b0;
            lkHit     <= 1'b0;
            lkOutPage <= '0;
        end
        else
        begin
            lkDone    <= lkValid;
            lkHit     <= lkValid && anyHit;
            lkOutPage <= (lkValid && anyHit) ? hitOut : '0;
        end
    end

    // all matches clear at this edge, so the ack follows them
    always_ff @(posedge clock)
    begin
        if (!rst_n)
            bcAck <= 1'b0;
        else
            bcAck <= bcValid;
    end

    // control register
    always_ff @(posedge clock)
    begin
        if (!rst_n)
            ctrl_r <= `TBI_CTRL_RST;
        else if (regWr && regAddr == `TBI_REG_CTRL)
            ctrl_r <= regWrData[`TBI_CTRL_W-1:0];
    end

    // broadcast statistics, saturating so software sees a ceiling
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            bcAccCnt_r  <= '0;
            bcDropCnt_r <= '0;
        end
        else if (bcValid)
        begin
            if (bcAccept && !(&bcAccCnt_r))
                bcAccCnt_r <= bcAccCnt_r + 1'b1;
            else if (!bcAccept && !(&bcDropCnt_r))
                bcDropCnt_r <= bcDropCnt_r + 1'b1;
        end
    end

    // lookup statistics
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            lkHitCnt_r  <= '0;
            lkMissCnt_r <= '0;
        end
        else if (lkValid)
        begin
            if (anyHit && !(&lkHitCnt_r))
                lkHitCnt_r <= lkHitCnt_r + 1'b1;
            else if (!anyHit && !(&lkMissCnt_r))
                lkMissCnt_r <= lkMissCnt_r + 1'b1;
        end
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge clock)
    begin
        if (!rst_n || !regRd)
            regRdData <= '0;
        else
        begin
            case (regAddr)
                `TBI_REG_CTRL:
                    regRdData <= {{(32-`TBI_CTRL_W){1'b0}}, ctrl_r};
                `TBI_REG_CAP:
                begin
                    regRdData <= '0;
                    regRdData[`TBI_CAPB_S1P]    <= `TBI_CAP_S1P;
                    regRdData[`TBI_CAPB_S2P]    <= `TBI_CAP_S2P;
                    regRdData[`TBI_CAPB_WIDE_ASID_CAPABILITY] <= `TBI_CAP_WIDE_ASID_CAPABILITY;
                    regRdData[`TBI_CAPB_WIDE_VMID_CAPABILITY] <= `TBI_CAP_WIDE_VMID_CAPABILITY;
                    regRdData[`TBI_CAPB_BTM]    <= `TBI_CAP_BTM;
                    regRdData[`TBI_CAPB_SEC]    <= `TBI_CAP_SEC;
                    regRdData[`TBI_CAPB_SEL2]   <= `TBI_CAP_SEL2;
                end
                `TBI_REG_OCC:
                    regRdData <= {{(31-`TBI_IDX_W){1'b0}}, occCount};
                `TBI_REG_BC_ACC:
                    regRdData <= {{(32-`TBI_CNT_W){1'b0}}, bcAccCnt_r};
                `TBI_REG_BC_DROP:
                    regRdData <= {{(32-`TBI_CNT_W){1'b0}}, bcDropCnt_r};
                `TBI_REG_LK_HIT:
                    regRdData <= {{(32-`TBI_CNT_W){1'b0}}, lkHitCnt_r};
                `TBI_REG_LK_MISS:
                    regRdData <= {{(32-`TBI_CNT_W){1'b0}}, lkMissCnt_r};
                default:
                    regRdData <= '0;
            endcase
        end
    end

endmodule
`default_nettype wire

//--- shared/tbi_defs.svh
`ifndef TBI_DEFS_SVH
`define TBI_DEFS_SVH

// table geometry
`define TBI_ENTRIES      8
`define TBI_IDX_W        3
`define TBI_PAGE_W       20
`define TBI_ID_W         16
`define TBI_CNT_W        16

// tag widths: narrow tags keep only the low byte
`define TBI_ID_WIDE_MASK   16'hffff
`define TBI_ID_NARROW_MASK 16'h00ff
`define TBI_ID_ZERO        16'h0000

// implemented features, fixed at build time
`define TBI_CAP_S1P      1'b1
`define TBI_CAP_S2P      1'b1
`define TBI_CAP_WIDE_ASID_CAPABILITY   1'b1
`define TBI_CAP_WIDE_VMID_CAPABILITY   1'b0
`define TBI_CAP_BTM      1'b1
`define TBI_CAP_SEC      1'b1
`define TBI_CAP_SEL2     1'b1

// world code that no regime uses
`define TBI_W_UNIMP      3'h7

// register offsets, byte addresses on the plain port
`define TBI_ADDR_W       8
`define TBI_REG_CTRL     8'h00
`define TBI_REG_CAP      8'h04
`define TBI_REG_OCC      8'h08
`define TBI_REG_BC_ACC   8'h0c
`define TBI_REG_BC_DROP  8'h10
`define TBI_REG_LK_HIT   8'h14
`define TBI_REG_LK_MISS  8'h18

// control register fields
`define TBI_CTRL_W       3
`define TBI_CTRL_PTM_NS  0
`define TBI_CTRL_PTM_S   1
`define TBI_CTRL_OUTER   2
`define TBI_CTRL_RST     3'h0

// capability register fields
`define TBI_CAPB_S1P     0
`define TBI_CAPB_S2P     1
`define TBI_CAPB_WIDE_ASID_CAPABILITY  2
`define TBI_CAPB_WIDE_VMID_CAPABILITY  3
`define TBI_CAPB_BTM     4
`define TBI_CAPB_SEC     5
`define TBI_CAPB_SEL2    6

`endif

//--- shared/tbi_pkg.sv
`default_nettype none
package tbi_pkg;

    // regime a translation was cached under
    typedef enum logic [2:0] {
        TBI_W_NSK   = 3'b000,
        TBI_W_NHYP  = 3'b001,
        TBI_W_NHYPH = 3'b010,
        TBI_W_SEC   = 3'b011,
        TBI_W_MON   = 3'b100,
        TBI_W_SHYP  = 3'b101,
        TBI_W_SHYPH = 3'b110
    } tbi_world_t;

    // scope of an invalidation, broadcast or queued
    typedef enum logic [1:0] {
        TBI_OP_ALL      = 2'b00,
        TBI_OP_ASID     = 2'b01,
        TBI_OP_ADDR     = 2'b10,
        TBI_OP_ADDR_ALL = 2'b11
    } tbi_op_t;

    // translation stages a broadcast names
    typedef enum logic [1:0] {
        TBI_ST_NONE = 2'b00,
        TBI_ST_S1   = 2'b01,
        TBI_ST_S2   = 2'b10,
        TBI_ST_S12  = 2'b11
    } tbi_stage_t;

endpackage
`default_nettype wire

//--- core/tbi_tag_build.sv
`timescale 1ns/1ps
`default_nettype none
`include "tbi_defs.svh"

module tbi_tag_build
    import tbi_pkg::*;
(
    // fill request
    input  wire tbi_pkg::tbi_world_t insWorld,
    input  wire logic                insIpa,
    input  wire logic                insNotGlobal,
    input  wire logic                insAset,
    input  wire logic [15:0]         insAsid,
    input  wire logic [15:0]         insVmid,
    // tags to store
    output logic                     tagAsidV,
    output logic [15:0]              tagAsid,
    output logic                     tagVmidV,
    output logic [15:0]              tagVmid,
    output logic                     tagAsetV,
    output logic                     tagAset
);
    import tbi_pkg::*;

    logic asidWorld;
    logic [15:0] asidMask;
    logic [15:0] vmidMask;

    // worlds that carry address space identifiers
    assign asidWorld = (insWorld == TBI_W_NSK) || (insWorld == TBI_W_NHYPH)
                    || (insWorld == TBI_W_SEC) || (insWorld == TBI_W_SHYPH);
    assign asidMask = `TBI_CAP_WIDE_ASID_CAPABILITY ? `TBI_ID_WIDE_MASK
                                      : `TBI_ID_NARROW_MASK;
    assign vmidMask = `TBI_CAP_WIDE_VMID_CAPABILITY ? `TBI_ID_WIDE_MASK
                                      : `TBI_ID_NARROW_MASK;

    // identifier only for non-global va entries of asid worlds
    assign tagAsidV = asidWorld && !insIpa && insNotGlobal;
    assign tagAsid  = tagAsidV ? (insAsid & asidMask) : `TBI_ID_ZERO;

    // flag kept for global and non-global va; hyp and monitor skip it
    assign tagAsetV = asidWorld && !insIpa;
    assign tagAset  = tagAsetV && insAset;

    // vm tag from the stream entry; absent without stage 2
    assign tagVmidV = (`TBI_CAP_S2P && insWorld == TBI_W_NSK)
                   || (`TBI_CAP_SEL2 && insWorld == TBI_W_SEC);
    assign tagVmid  = tagVmidV ? (insVmid & vmidMask)
                               : `TBI_ID_ZERO;

endmodule
`default_nettype wire

//--- core/tbi_bcast_filter.sv
`timescale 1ns/1ps
`default_nettype none
`include "tbi_defs.svh"

module tbi_bcast_filter
    import tbi_pkg::*;
(
    // incoming message
    input  wire logic                bcValid,
    input  wire tbi_pkg::tbi_world_t bcWorld,
    input  wire tbi_pkg::tbi_stage_t bcStage,
    input  wire logic                bcOuter,
    input  wire logic                bcNoEl2,
    input  wire logic [15:0]         bcVmid,
    // software control
    input  wire logic                ptmNonSec,
    input  wire logic                ptmSec,
    input  wire logic                devOuter,
    // verdict
    output logic                     accept,
    output logic                     s1Eff,
    output logic                     s2Eff,
    output logic [15:0]              effVmid
);
    import tbi_pkg::*;

    logic secure;
    logic worldOk;
    logic scopeOk;
    logic ptmOk;
    logic [15:0] vmidMask;

    assign secure = (bcWorld == TBI_W_SEC) || (bcWorld == TBI_W_MON)
                 || (bcWorld == TBI_W_SHYP) || (bcWorld == TBI_W_SHYPH);

    // unimplemented regimes are dropped, yet still acked and counted as drops
    assign worldOk = (!secure || `TBI_CAP_SEC)
                  && !((bcWorld == TBI_W_SHYP || bcWorld == TBI_W_SHYPH)
                       && !`TBI_CAP_SEL2)
                  && (bcWorld != `TBI_W_UNIMP);

    // outer scope reaches inner members too
    assign scopeOk = bcOuter || !devOuter;
    assign ptmOk   = secure ? !ptmSec : !ptmNonSec;

    // combined stage keeps only what exists
    assign s1Eff = bcStage[0] && `TBI_CAP_S1P;
    assign s2Eff = bcStage[1] && `TBI_CAP_S2P;

    assign accept = bcValid && `TBI_CAP_BTM && worldOk && scopeOk
                 && ptmOk && (s1Eff || s2Eff);

    assign vmidMask = `TBI_CAP_WIDE_VMID_CAPABILITY ? `TBI_ID_WIDE_MASK
                                      : `TBI_ID_NARROW_MASK;
    // no stage 2, or sender without a hypervisor: vm 0
    assign effVmid = (!`TBI_CAP_S2P || bcNoEl2) ? `TBI_ID_ZERO
                                                 : (bcVmid & vmidMask);

endmodule
`default_nettype wire

//--- verification/tbi_tlb_tags_properties.sv
`timescale 1ns/1ps
`default_nettype none
module tbi_tlb_tags_properties (
    // clock and reset
    input wire logic        clock,
    input wire logic        rst_n,
    // watched ports
    input wire logic [7:0]  regAddr,
    input wire logic        regRd,
    input wire logic [31:0] regRdData,
    input wire logic        lkValid,
    input wire logic        lkDone,
    input wire logic        lkHit,
    input wire logic [19:0] lkOutPage,
    input wire logic        bcValid,
    input wire logic        bcAck
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    // a lookup answers on the next cycle
    sequence lkStep;
        lkValid ##1 lkDone;
    endsequence
    lk_ans_a: assert property (lkValid |-> lkStep)
        else $error("no done");
    lk_idle_a: assert property (!lkValid |=> !lkDone) else $error("done");
    hit_done_a: assert property (lkHit |-> lkDone)
        else $error("hit");
    miss_page_a: assert property (
        lkDone && !lkHit |-> lkOutPage == 20'h0) else $error("miss page");
    bc_ack_a: assert property (bcValid |=> bcAck)
        else $error("no ack");
    bc_idle_a: assert property (!bcValid |=> !bcAck) else $error("ack");
    rd_idle_a: assert property (!regRd |=> regRdData == 32'h0) else $error("rd");
    cap_rd_a: assert property (
        regRd && regAddr == 8'h04 |=> regRdData == 32'h77) else $error("cap");
endmodule
bind tbi_tlb_tags tbi_tlb_tags_properties tbi_tlb_tags_properties_i (.*);
`default_nettype wire

//--- verification/tbi_bcast_src.sv
`timescale 1ns/1ps
`default_nettype none
module tbi_bcast_src
    import tbi_pkg::*;
(
    // clock
    input  wire logic           clock,
    // broadcast message
    output logic                bcValid,
    output logic                bcOuter,
    output logic                bcNoEl2,
    output tbi_pkg::tbi_op_t    bcOp,
    output tbi_pkg::tbi_world_t bcWorld,
    output tbi_pkg::tbi_stage_t bcStage,
    output logic [15:0]         bcAsid,
    output logic [15:0]         bcVmid,
    output logic [19:0]         bcPage
);
    // senders own a hypervisor level unless told otherwise
    initial
    begin
        {bcValid, bcNoEl2, bcOuter, bcAsid, bcVmid, bcPage} = '0;
        bcOp = TBI_OP_ALL;
        bcWorld = TBI_W_NSK;
        bcStage = TBI_ST_NONE;
    end
    // op, regime, stage and ids travel together
    task automatic send(tbi_op_t o, tbi_world_t w, tbi_stage_t s,
                        logic out, logic ne, logic [15:0] id);
        @(posedge clock);
        {bcValid, bcOuter, bcAsid, bcVmid, bcPage} <= {1'b1, out, id,
            16'h0023, 4'h0, id};
        bcOp <= o;
        bcWorld <= w;
        bcStage <= s;
        bcNoEl2 <= ne;
        @(posedge clock);
        bcValid <= 0;
        // stale fields flipped so nothing leans on them
        {bcOuter, bcAsid, bcPage} <= ~{bcOuter, bcAsid, bcPage};
    endtask
endmodule
`default_nettype wire

//--- verification/tbi_tlb_tags_tb.sv
`timescale 1ns/1ps
`default_nettype none
module tbi_tlb_tags_tb;
    import tbi_pkg::*;
    logic clock = 0, rst_n = 0, regWr = 0, regRd = 0, insValid = 0;
    logic insIpa = 0, insNotGlobal = 0, insAset = 0, lkValid = 0, lkIpa = 0;
    logic lkAset = 0, cmdValid = 0, cmdIpa = 0, lkDone, lkHit, bcAck;
    logic bcValid, bcOuter, bcNoEl2;
    logic [7:0] regAddr = 0;
    logic [31:0] regWrData = 0, regRdData;
    logic [15:0] insAsid = 0, insVmid = 0, lkAsid = 0, lkVmid = 0;
    logic [15:0] cmdAsid = 0, cmdVmid = 0, bcAsid, bcVmid;
    logic [19:0] insPage = 0, insOutPage = 0, lkPage = 0, cmdPage = 0;
    logic [19:0] bcPage, lkOutPage;
    tbi_world_t insWorld = TBI_W_NSK, lkWorld = TBI_W_NSK;
    tbi_world_t cmdWorld = TBI_W_NSK, bcWorld;
    tbi_op_t cmdOp = TBI_OP_ALL, bcOp;
    tbi_stage_t bcStage;
    int fail_count = 0, n_checks = 0;
    always #5 clock = ~clock;
    tbi_tlb_tags tbi_tlb_tags_i (.*);
    tbi_bcast_src tbi_bcast_src_i (.*);
    task automatic chk(logic [31:0] s, logic [31:0] e);
        n_checks++;
        if (s !== e)
        begin
            fail_count++;
            $display("unexpected %0t got %h want %h", $time, s, e);
        end
    endtask
    // register write (w=1) or read compared against d
    task automatic acc(logic w, logic [7:0] a, logic [31:0] d);
        @(posedge clock);
        {regWr, regRd, regAddr, regWrData} <= {w, !w, a, d};
        @(posedge clock);
        {regWr, regRd} <= 2'b00;
        #1 if (!w) chk(regRdData, d);
    endtask
    // fill (f=1) or lookup; output page is always the inverted id
    task automatic ent(logic f, tbi_world_t w, logic s, logic [15:0] id,
                       logic e);
        @(posedge clock);
        {insValid, lkValid, insNotGlobal, insAset} <= {f, !f, 1'b1, s};
        insWorld <= w;
        lkWorld <= w;
        {insAsid, lkAsid, insVmid, lkVmid} <= {id, id, 16'h0123, 16'h23};
        {insPage, lkPage, insOutPage} <= {4'h0, id, 4'h0, id, 4'h0, ~id};
        @(posedge clock);
        {insValid, lkValid} <= 2'b00;
        #1 if (!f) chk({lkHit, lkOutPage}, e ? {1'b1, 4'h0, ~id} : 0);
    endtask
    task automatic final_report;
        $display("checks %0d errors %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // watchdog well past the roughly 55 cycles of tests
    initial
    begin
        #20000;
        fail_count++;
        final_report;
    end
    initial
    begin
        repeat (3) @(posedge clock);
        rst_n <= 1;
        acc(0, 8'h04, 32'h77);
        acc(0, 8'h1c, 0);
        ent(1, TBI_W_NSK, 0, 16'h5, 0);
        ent(1, TBI_W_SEC, 1, 16'h6, 0);
        ent(0, TBI_W_NSK, 0, 16'h5, 1);
        ent(0, TBI_W_SEC, 0, 16'h5, 0);
        ent(0, TBI_W_NSK, 0, 16'h6, 0);
        ent(0, TBI_W_SEC, 0, 16'h6, 1);
        acc(1, 8'h00, 32'h1);
        tbi_bcast_src_i.send(TBI_OP_ASID, TBI_W_NSK, TBI_ST_S1, 0, 0, 16'h5);
        ent(0, TBI_W_NSK, 0, 16'h5, 1);
        acc(1, 8'h00, 32'h4);
        tbi_bcast_src_i.send(TBI_OP_ASID, TBI_W_NSK, TBI_ST_S1, 0, 0, 16'h5);
        ent(0, TBI_W_NSK, 0, 16'h5, 1);
        acc(0, 8'h10, 32'h2);
        tbi_bcast_src_i.send(TBI_OP_ASID, TBI_W_NSK, TBI_ST_S1, 1, 0, 16'h5);
        ent(0, TBI_W_NSK, 0, 16'h5, 0);
        tbi_bcast_src_i.send(TBI_OP_ASID, TBI_W_SEC, TBI_ST_S1, 1, 0, 16'h6);
        ent(0, TBI_W_SEC, 0, 16'h6, 1);
        // queued invalidate ignores the private flag
        @(posedge clock);
        {cmdValid, cmdAsid, cmdVmid} <= {1'b1, 16'h6, 16'h23};
        {cmdOp, cmdWorld} <= {TBI_OP_ASID, TBI_W_SEC};
        @(posedge clock);
        cmdValid <= 0;
        ent(0, TBI_W_SEC, 0, 16'h6, 0);
        // sender without a hypervisor means vm 0, so the entry survives
        ent(1, TBI_W_NSK, 0, 16'h7, 0);
        tbi_bcast_src_i.send(TBI_OP_ALL, TBI_W_NSK, TBI_ST_S1, 1, 1, 16'h7);
        ent(0, TBI_W_NSK, 0, 16'h7, 1);
        tbi_bcast_src_i.send(TBI_OP_ALL, TBI_W_NSK, TBI_ST_S1, 1, 0, 16'h7);
        ent(0, TBI_W_NSK, 0, 16'h7, 0);
        final_report;
    end
endmodule
`default_nettype wire
